// >>> line_seq_clamp.sv
`timescale 1ns/1ps
`include "lsic_consts.svh"
// Overview of operation
// - Line mode samples one input per line, advancing on each sync
// - Line-mode colour order comes from a configuration register
// - First sync after entry or restart applies entry 0 gain and offset
// - Later syncs step to next entry, wrap after third, loop forever
// - Line-mode channel and converter rate held at or below 30MSPS
// - Clamp pulse begins set pixels after sync and lasts set pixels
// - Active clamp pulse closes switch tying inputs to clamp reference
// - Gated clamp is clamp pulse AND internal sample strobe
// - Config bit selects sample-and-hold or correlated double sampling
// - In CDS mode resistor dividers switch across chosen inputs instead
// - Bit 7 of first main configuration enables all source followers
// - Bit 4 of second configuration selects small range, gain two
// - Three-input slot order programmable, restarts on sync, 3x rate
module line_seq_clamp (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Sensor timing
   input wire logic line_sync_pulse_in,
   input wire logic sample_strobe_in,
   // Input selection and coefficients
   output logic [2:0] input_enable_out,
   output lsic_pkg::chan_t adc_channel_out,
   output logic conv_strobe_out,
   output logic [7:0] gain_out,
   output logic [9:0] offset_out,
   // Bias and front end control
   output logic [2:0] clamp_switch_out,
   output logic [2:0] divider_enable_out,
   output logic cds_mode_out,
   output logic source_follower_out,
   output logic range_small_out,
   output logic sampling_gain_x2_out
);
   import lsic_pkg::*;

   coef_if coef_bus ();

   coef_mem u_coef_mem (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .coef_port(coef_bus.mem)
   );

   // Configuration
   logic sf_ff;
   logic range_ff;
   logic [1:0] mode_ff;
   logic [7:0] div_ff;
   logic [5:0] order_ff;
   logic [`CLP_W-1:0] clp_dly_ff;
   logic [`CLP_W-1:0] clp_wid_ff;
   logic cds_ff;
   logic gate_ff;
   logic [2:0] div_en_ff;
   // Bus
   logic [31:0] rd_data_ff;
   logic err_ff;
   logic [31:0] rd_word;
   logic rd_err;
   logic wr_acc;
   logic seq_restart;
   // Sequencing
   seq_state_e state_ff;
   logic [1:0] idx_ff;
   logic [1:0] nxt_idx;
   chan_t active_ch_ff;
   logic [1:0] slot_ff;
   logic [7:0] div_cnt_ff;
   logic [7:0] eff_div;
   logic sync_prev_ff;
   logic line_sync;
   logic lseq;
   logic sync3;
   logic conv_en;
   logic pix_en;
   chan_t adc_ch;
   logic [2:0] input_en_ff;
   chan_t adc_ch_ff;
   logic conv_ff;
   // Clamp
   logic [`CLP_CNT_W-1:0] clp_cnt_ff;
   logic input_clamp_pulse;
   logic gated_clamp_pulse;
   logic clamp_src;
   logic [2:0] clamp_sw_ff;
   logic [2:0] div_out_ff;

   function automatic logic [7:0] at_least(input logic [7:0] v,
      input logic [7:0] floor_v);
      at_least = (v < floor_v) ? floor_v : v;
   endfunction

   function automatic chan_t order_sel(input logic [5:0] order,
      input logic [1:0] pos);
      chan_t ch;
      ch = 2'h0;
      if (pos == 2'h0) begin
         ch = order[1:0];
      end else if (pos == 2'h1) begin
         ch = order[3:2];
      end else begin
         ch = order[5:4];
      end
      // Code 3 falls back to red
      order_sel = (ch == 2'h3) ? 2'h0 : ch;
   endfunction

   assign lseq = (mode_ff == `MODE_LSEQ);
   assign sync3 = (mode_ff == `MODE_SYNC3);
   assign line_sync = line_sync_pulse_in && !sync_prev_ff;
   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign seq_restart = wr_acc && (paddr_in == `ADDR_MODE);

   // APB read decode, captured in the setup cycle
   always_comb begin
      rd_word = 32'h0;
      rd_err = 1'b0;
      if (paddr_in == `ADDR_CFG1) begin
         rd_word[`CFG1_SF_BIT] = sf_ff;
      end else if (paddr_in == `ADDR_CFG2) begin
         rd_word[`CFG2_RANGE_BIT] = range_ff;
      end else if (paddr_in == `ADDR_MODE) begin
         rd_word = {16'h0, div_ff, 6'h0, mode_ff};
      end else if (paddr_in == `ADDR_ORDER) begin
         rd_word = {26'h0, order_ff};
      end else if (paddr_in == `ADDR_CLP_DLY) begin
         rd_word = {20'h0, clp_dly_ff};
      end else if (paddr_in == `ADDR_CLP_WID) begin
         rd_word = {20'h0, clp_wid_ff};
      end else if (paddr_in == `ADDR_BIAS) begin
         rd_word = {25'h0, div_en_ff, 2'h0, gate_ff, cds_ff};
      end else if (paddr_in == `ADDR_STATUS) begin
         rd_word = {24'h0, slot_ff, idx_ff, input_clamp_pulse,
            state_ff == SEQ_RUN, active_ch_ff};
      end else if (paddr_in == `ADDR_COEF_R || paddr_in == `ADDR_COEF_G ||
         paddr_in == `ADDR_COEF_B) begin
         rd_word = 32'h0;
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_ff <= 32'h0;
         err_ff <= 1'b0;
      end else if (psel_in && !penable_in) begin
         rd_data_ff <= pwrite_in ? 32'h0 : rd_word;
         err_ff <= rd_err;
      end
   end

   assign pready_out = psel_in && penable_in;
   assign pslverr_out = psel_in && penable_in && err_ff;
   assign prdata_out = rd_data_ff;

   // Register writes
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sf_ff <= 1'b0;
         range_ff <= 1'b0;
         mode_ff <= `MODE_RST;
         div_ff <= `DIV_RST;
         order_ff <= `ORDER_RST;
         clp_dly_ff <= `CLP_DLY_RST;
         clp_wid_ff <= `CLP_WID_RST;
         cds_ff <= 1'b0;
         gate_ff <= 1'b0;
         div_en_ff <= 3'h0;
      end else if (wr_acc) begin
         if (paddr_in == `ADDR_CFG1) begin
            sf_ff <= pwdata_in[`CFG1_SF_BIT];
         end else if (paddr_in == `ADDR_CFG2) begin
            range_ff <= pwdata_in[`CFG2_RANGE_BIT];
         end else if (paddr_in == `ADDR_MODE) begin
            mode_ff <= pwdata_in[1:0];
            div_ff <= pwdata_in[`MODE_DIV_LO +: 8];
         end else if (paddr_in == `ADDR_ORDER) begin
            order_ff <= pwdata_in[5:0];
         end else if (paddr_in == `ADDR_CLP_DLY) begin
            clp_dly_ff <= pwdata_in[`CLP_W-1:0];
         end else if (paddr_in == `ADDR_CLP_WID) begin
            clp_wid_ff <= pwdata_in[`CLP_W-1:0];
         end else if (paddr_in == `ADDR_BIAS) begin
            cds_ff <= pwdata_in[`BIAS_CDS_BIT];
            gate_ff <= pwdata_in[`BIAS_GATE_BIT];
            div_en_ff <= pwdata_in[`BIAS_DIV_LO +: 3];
         end
      end
   end

   // Coefficient writes go to the memory
   assign coef_bus.wr_en = wr_acc && (paddr_in == `ADDR_COEF_R ||
      paddr_in == `ADDR_COEF_G || paddr_in == `ADDR_COEF_B);
   assign coef_bus.wr_addr = 2'(paddr_in[3:2] + 2'h0);
   assign coef_bus.wr_data = pwdata_in[`COEF_W-1:0];

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync_prev_ff <= 1'b0;
      end else begin
         sync_prev_ff <= line_sync_pulse_in;
      end
   end

   // Line-sequential input sequencer
   always_comb begin
      nxt_idx = 2'h0;
      if (state_ff == SEQ_RUN && idx_ff != 2'h2) begin
         nxt_idx = 2'(idx_ff + 2'h1);
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_ff <= SEQ_WAIT;
         idx_ff <= 2'h0;
         active_ch_ff <= 2'h0;
      end else if (!lseq || seq_restart) begin
         state_ff <= SEQ_WAIT;
         idx_ff <= 2'h0;
      end else if (line_sync) begin
         idx_ff <= nxt_idx;
         active_ch_ff <= order_sel(order_ff, nxt_idx);
         case (state_ff)
            SEQ_WAIT: begin
               state_ff <= SEQ_RUN;
            end
            SEQ_RUN: begin
               state_ff <= SEQ_RUN;
            end
            default: begin
               state_ff <= SEQ_WAIT;
            end
         endcase
      end
   end

   // Conversion rate divider, realigned on each sync
   assign eff_div = at_least(div_ff,
      sync3 ? 8'(`ADC_MIN_DIV) : 8'(`LSEQ_MIN_DIV));
   assign conv_en = (sync3 || (lseq && state_ff == SEQ_RUN)) &&
      (div_cnt_ff == 8'(eff_div - 8'h1));

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         div_cnt_ff <= 8'h0;
      end else if (line_sync || div_cnt_ff >= 8'(eff_div - 8'h1)) begin
         div_cnt_ff <= 8'h0;
      end else begin
         div_cnt_ff <= 8'(div_cnt_ff + 8'h1);
      end
   end

   // Three-input slot order
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         slot_ff <= 2'h0;
      end else if (line_sync || !sync3) begin
         slot_ff <= 2'h0;
      end else if (conv_en) begin
         slot_ff <= (slot_ff == 2'h2) ? 2'h0 : 2'(slot_ff + 2'h1);
      end
   end

   assign pix_en = lseq ? conv_en : (conv_en && slot_ff == 2'h2);
   assign adc_ch = lseq ? active_ch_ff : order_sel(order_ff, slot_ff);
   assign coef_bus.rd_addr = adc_ch;

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         input_en_ff <= 3'h0;
         adc_ch_ff <= 2'h0;
         conv_ff <= 1'b0;
      end else begin
         conv_ff <= conv_en;
         if (conv_en) begin
            adc_ch_ff <= adc_ch;
         end
         if (lseq && state_ff == SEQ_RUN) begin
            input_en_ff <= 3'(3'h1 << active_ch_ff);
         end else if (sync3) begin
            input_en_ff <= 3'h7;
         end else begin
            input_en_ff <= 3'h0;
         end
      end
   end

   // Clamp pixel counter, saturating at its all-ones maximum
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         clp_cnt_ff <= `CLP_CNT_MAX;
      end else if (line_sync) begin
         clp_cnt_ff <= '0;
      end else if (pix_en && clp_cnt_ff != `CLP_CNT_MAX) begin
         clp_cnt_ff <= `CLP_CNT_W'(clp_cnt_ff + 1'b1);
      end
   end

   assign input_clamp_pulse = (clp_cnt_ff >= {1'b0, clp_dly_ff}) &&
      (clp_cnt_ff < `CLP_CNT_W'({1'b0, clp_dly_ff} +
      {1'b0, clp_wid_ff}));
   assign gated_clamp_pulse = input_clamp_pulse &&
      sample_strobe_in;
   assign clamp_src = gate_ff ? gated_clamp_pulse :
      input_clamp_pulse;

   // Divider-biased inputs in CDS mode need no clamp
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         clamp_sw_ff <= 3'h0;
         div_out_ff <= 3'h0;
      end else begin
         clamp_sw_ff <= {3{clamp_src}} &
            ~(cds_ff ? div_en_ff : 3'h0);
         div_out_ff <= cds_ff ? div_en_ff : 3'h0;
      end
   end

   assign input_enable_out = input_en_ff;
   assign adc_channel_out = adc_ch_ff;
   assign conv_strobe_out = conv_ff;
   assign gain_out = coef_bus.rd_data[7:0];
   assign offset_out = coef_bus.rd_data[17:8];
   assign clamp_switch_out = clamp_sw_ff;
   assign divider_enable_out = div_out_ff;
   assign cds_mode_out = cds_ff;
   assign source_follower_out = sf_ff;
   assign range_small_out = range_ff;
   assign sampling_gain_x2_out = range_ff;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);

   a_seq_first_entry: assert property (
      lseq && !seq_restart && state_ff == SEQ_WAIT && line_sync |=>
      state_ff == SEQ_RUN && idx_ff == 2'h0 &&
      active_ch_ff == order_sel($past(order_ff), 2'h0))
      else $error("first sync did not select first entry");
   a_seq_wrap_third: assert property (
      lseq && !seq_restart && state_ff == SEQ_RUN && idx_ff == 2'h2 &&
      line_sync |=> idx_ff == 2'h0)
      else $error("sequence did not wrap after third entry");
   a_seq_step_next: assert property (
      lseq && !seq_restart && state_ff == SEQ_RUN && idx_ff < 2'h2 &&
      line_sync |=> idx_ff == $past(idx_ff) + 2'h1)
      else $error("sequence did not advance on sync");
   a_one_input_only: assert property (
      lseq && state_ff == SEQ_RUN && $past(lseq && state_ff == SEQ_RUN) |=>
      $onehot(input_enable_out))
      else $error("more than one input sampled in line mode");
   a_lseq_rate_cap: assert property (
      lseq && conv_en && !line_sync |=> !(lseq && conv_en) [*4])
      else $error("line mode conversion faster than limit");
   a_clamp_restart: assert property (
      line_sync |=> clp_cnt_ff == '0)
      else $error("clamp counter not restarted on sync");
   a_clamp_gated: assert property (
      gate_ff && !cds_ff && !(input_clamp_pulse && sample_strobe_in) |=>
      clamp_switch_out == 3'h0)
      else $error("gated clamp closed outside sample strobe");
   a_clamp_closes: assert property (
      !cds_ff && !gate_ff && input_clamp_pulse |=> clamp_switch_out == 3'h7)
      else $error("clamp switch open during clamp pulse");
   a_sh_no_divider: assert property (
      !cds_ff |=> divider_enable_out == 3'h0)
      else $error("divider bias enabled in sample and hold mode");
   a_sf_follows_bit: assert property (
      wr_acc && paddr_in == `ADDR_CFG1 |=>
      source_follower_out == $past(pwdata_in[`CFG1_SF_BIT]))
      else $error("source follower not set from bit 7");
   a_range_gain_two: assert property (
      wr_acc && paddr_in == `ADDR_CFG2 |=>
      range_small_out == $past(pwdata_in[`CFG2_RANGE_BIT]) &&
      sampling_gain_x2_out == range_small_out)
      else $error("input range bit not applied");
   a_sync3_slot_align: assert property (
      sync3 && line_sync |=> slot_ff == 2'h0)
      else $error("three-input slot not aligned to sync");

   c_seq_wrap: cover property (lseq && idx_ff == 2'h2 && line_sync);
   c_gated_clamp: cover property (gate_ff && gated_clamp_pulse);
   c_sync3_slot2: cover property (sync3 && conv_en && slot_ff == 2'h2);
   c_apb_error: cover property (pslverr_out);
endmodule

// >>> lsic_consts.svh
`ifndef LSIC_CONSTS_SVH
`define LSIC_CONSTS_SVH

// Clock and converter rates
`define CLK_MHZ 125
`define LSEQ_MAX_MSPS 30
`define ADC_MAX_MSPS 45
`define LSEQ_MIN_DIV ((`CLK_MHZ + `LSEQ_MAX_MSPS - 1) / `LSEQ_MAX_MSPS)
`define ADC_MIN_DIV ((`CLK_MHZ + `ADC_MAX_MSPS - 1) / `ADC_MAX_MSPS)

// Register byte offsets
`define ADDR_CFG1 12'h000
`define ADDR_CFG2 12'h004
`define ADDR_MODE 12'h008
`define ADDR_ORDER 12'h00c
`define ADDR_CLP_DLY 12'h010
`define ADDR_CLP_WID 12'h014
`define ADDR_BIAS 12'h018
`define ADDR_STATUS 12'h01c
`define ADDR_COEF_R 12'h020
`define ADDR_COEF_G 12'h024
`define ADDR_COEF_B 12'h028

// Field positions
`define CFG1_SF_BIT 7
`define CFG2_RANGE_BIT 4
`define MODE_RESTART_BIT 2
`define MODE_DIV_LO 8
`define BIAS_CDS_BIT 0
`define BIAS_GATE_BIT 1
`define BIAS_DIV_LO 4

// Mode codes
`define MODE_SYNC3 2'h0
`define MODE_LSEQ 2'h1

// Widths
`define COEF_W 18
`define CLP_W 12
`define CLP_CNT_W 13

// Reset values
`define MODE_RST 2'h0
`define ORDER_RST 6'h24
`define DIV_RST 8'h05
`define CLP_DLY_RST 12'h000
`define CLP_WID_RST 12'h010
`define COEF_RST 18'h00100
`define CLP_CNT_MAX 13'h1fff

`endif

// >>> lsic_pkg.sv
`include "lsic_consts.svh"
package lsic_pkg;
   typedef logic [1:0] chan_t;
   typedef logic [`COEF_W-1:0] coef_t;
   typedef enum logic [1:0] {
      SEQ_WAIT = 2'b01,
      SEQ_RUN = 2'b10
   } seq_state_e;
endpackage

// >>> coef_if.sv
`timescale 1ns/1ps
interface coef_if;
   import lsic_pkg::*;
   logic wr_en;
   chan_t wr_addr;
   coef_t wr_data;
   chan_t rd_addr;
   coef_t rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data,
      output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data,
      input rd_addr, output rd_data);
endinterface

// >>> coef_mem.sv
`timescale 1ns/1ps
`include "lsic_consts.svh"
module coef_mem (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Coefficient port
   coef_if.mem coef_port
);
   import lsic_pkg::*;

   coef_t mem_ff [0:2];
   coef_t rd_data_ff;

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < 3; i++) begin
            mem_ff[i] <= `COEF_RST;
         end
      end else if (coef_port.wr_en && coef_port.wr_addr != 2'h3) begin
         mem_ff[coef_port.wr_addr] <= coef_port.wr_data;
      end
   end

   // Code 3 never reaches here; it reads the red entry
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_ff <= `COEF_RST;
      end else if (coef_port.rd_addr == 2'h3) begin
         rd_data_ff <= mem_ff[0];
      end else begin
         rd_data_ff <= mem_ff[coef_port.rd_addr];
      end
   end

   assign coef_port.rd_data = rd_data_ff;
endmodule

// >>> sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Strobe level chosen by the bench
   input wire logic strobe_level_in,
   // Timing toward the front end
   output logic line_sync_pulse_out,
   output logic sample_strobe_out
);
   logic sync_ff = 1'b0;

   assign line_sync_pulse_out = sync_ff;

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sample_strobe_out <= 1'b0;
      end else begin
         sample_strobe_out <= strobe_level_in;
      end
   end

   // Start of a line: sync high for two clocks, then low again
   task automatic send_line();
      @(posedge clock_in);
      sync_ff <= 1'b1;
      repeat (2) @(posedge clock_in);
      sync_ff <= 1'b0;
      @(posedge clock_in);
   endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ps
`include "lsic_consts.svh"
module tb;
   import lsic_pkg::*;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, line_sync, sample_strobe, strobe_level = 1'b0;
   logic [2:0] in_en, clamp, div_en;
   chan_t adc_ch;
   logic conv, cds, sf, rng, gx2;
   logic [7:0] gain;
   logic [9:0] offset;
   logic [31:0] rd;
   logic er;
   int err_count = 0;
   int n_tests = 0;
   int nc, ns;
   logic [2:0] orv;
   chan_t ord [3] = '{2'h2, 2'h0, 2'h1};
   logic [31:0] coef [3] = '{32'h00010111, 32'h00020222, 32'h00030333};
   logic [31:0] bias [4] = '{32'h00, 32'h02, 32'h02, 32'h31};
   logic stb [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   int exp_n [4] = '{15, 0, 15, 15};
   logic [2:0] exp_or [4] = '{3'h7, 3'h0, 3'h7, 3'h4};
   chan_t c;

   always #4 clock_in = ~clock_in;

   sensor_model u_sensor (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .strobe_level_in(strobe_level), .line_sync_pulse_out(line_sync),
      .sample_strobe_out(sample_strobe));

   line_seq_clamp u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .line_sync_pulse_in(line_sync), .sample_strobe_in(sample_strobe),
      .input_enable_out(in_en), .adc_channel_out(adc_ch),
      .conv_strobe_out(conv), .gain_out(gain), .offset_out(offset),
      .clamp_switch_out(clamp), .divider_enable_out(div_en),
      .cds_mode_out(cds), .source_follower_out(sf),
      .range_small_out(rng), .sampling_gain_x2_out(gx2));

   task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do @(posedge clock_in); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the write settle before outputs are compared
      #1;
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a,
      input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   // Counts clamp and conversion activity over n settled clocks
   task automatic watch(input int n);
      nc = 0;
      ns = 0;
      orv = 3'h0;
      repeat (n) begin
         @(posedge clock_in);
         #1;
         if (clamp !== 3'h0) nc++;
         if (conv === 1'b1) ns++;
         orv = orv | clamp;
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock_in);
      err_count++;
      summarize();
   end

   initial begin
      repeat (2) @(posedge clock_in);
      rst_b_in <= 1'b1;
      chk("offset rst", 32'(`COEF_RST >> 8), 32'(offset));
      rdchk("mode rst", `ADDR_MODE, 32'h500);
      rdchk("order rst", `ADDR_ORDER, 32'h24);
      rdchk("delay rst", `ADDR_CLP_DLY, 32'h0);
      rdchk("width rst", `ADDR_CLP_WID, 32'h10);
      rdchk("coef wo", `ADDR_COEF_G, 32'h0);
      rdchk("unmapped", 12'h030, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      $display("test reset done");
      xfer(1'b1, `ADDR_CFG2, 32'h10);
      xfer(1'b1, `ADDR_CFG1, 32'h80);
      chk("follower", 32'h1, 32'(sf));
      chk("range", 32'h3, 32'({rng, gx2}));
      xfer(1'b1, `ADDR_CFG1, 32'h00);
      xfer(1'b1, `ADDR_CFG2, 32'h00);
      chk("range off", 32'h0, 32'({sf, rng, gx2}));
      $display("test front end done");
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, 12'(`ADDR_COEF_R + 4 * i), coef[i]);
      end
      xfer(1'b1, `ADDR_ORDER, 32'h12);
      xfer(1'b1, `ADDR_MODE, 32'h305);
      rdchk("mode", `ADDR_MODE, 32'h301);
      repeat (8) @(posedge clock_in);
      chk("idle enable", 32'h0, 32'(in_en));
      for (int k = 0; k < 4; k++) begin
         c = ord[k % 3];
         u_sensor.send_line();
         repeat (3) @(posedge clock_in);
         chk("enable", 32'(3'h1 << c), 32'(in_en));
         chk("gain", 32'(coef[c][7:0]), 32'(gain));
         chk("offset", 32'(coef[c][17:8]), 32'(offset));
         watch(50);
         chk("conv count", 32'(50 / `LSEQ_MIN_DIV), 32'(ns));
         chk("adc channel", 32'(c), 32'(adc_ch));
      end
      xfer(1'b1, `ADDR_MODE, 32'h301);
      u_sensor.send_line();
      repeat (3) @(posedge clock_in);
      chk("restart", 32'(3'h1 << ord[0]), 32'(in_en));
      $display("test line sequence done");
      xfer(1'b1, `ADDR_CLP_DLY, 32'h2);
      xfer(1'b1, `ADDR_CLP_WID, 32'h3);
      for (int j = 0; j < 4; j++) begin
         xfer(1'b1, `ADDR_BIAS, bias[j]);
         strobe_level <= stb[j];
         u_sensor.send_line();
         watch(60);
         chk("clamp cycles", 32'(exp_n[j]), 32'(nc));
         chk("clamp inputs", 32'(exp_or[j]), 32'(orv));
      end
      chk("cds", 32'h1, 32'(cds));
      chk("dividers", 32'h3, 32'(div_en));
      $display("test clamp done");
      xfer(1'b1, `ADDR_BIAS, 32'h0);
      xfer(1'b1, `ADDR_MODE, 32'h300);
      u_sensor.send_line();
      repeat (3) @(posedge clock_in);
      chk("three enable", 32'h7, 32'(in_en));
      chk("sh mode", 32'h0, 32'(cds));
      watch(60);
      chk("three rate", 32'(60 / `ADC_MIN_DIV), 32'(ns));
      // Codes 2 and 3 leave every input off and the converter quiet
      xfer(1'b1, `ADDR_MODE, 32'h302);
      repeat (2) @(posedge clock_in);
      chk("idle mode", 32'h0, 32'(in_en));
      watch(10);
      chk("idle conv", 32'd0, 32'(ns));
      $display("test three input done");
      summarize();
   end
endmodule
